// File: shared/scr_pkg.sv
// constants shared by the sysref clock control register bank
// assumes a single 40 MHz core clock; serial port pins are asynchronous
package scr_pkg;

  // ----------------------------------------------------------------------
  // serial frame layout
  // ----------------------------------------------------------------------
  localparam int unsigned SCR_SYNC_W     = 4;     // pins passed through sync
  localparam int unsigned SCR_BIT_RW     = 15;    // header bit: 1 = read
  localparam logic [3:0]  SCR_HDR_LAST   = 4'hF;  // 16 header bits
  localparam logic [3:0]  SCR_BYTE_LAST  = 4'h7;  // 8 data bits per byte

  // ----------------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------------
  localparam logic [14:0] SCR_OFS_CONFIG_A   = 15'h0000;
  localparam logic [14:0] SCR_OFS_USER_CFG   = 15'h0010;
  localparam logic [14:0] SCR_OFS_CLK_SYSREF = 15'h0029;
  localparam logic [14:0] SCR_OFS_CLK_INMODE = 15'h002A;
  localparam logic [14:0] SCR_OFS_CLK_NOISE  = 15'h002B;
  localparam logic [14:0] SCR_OFS_EDGE_POS0  = 15'h002C;
  localparam logic [14:0] SCR_OFS_EDGE_POS1  = 15'h002D;
  localparam logic [14:0] SCR_OFS_EDGE_POS2  = 15'h002E;

  // ----------------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------------
  localparam logic [7:0] SCR_RST_CONFIG_A   = 8'h30;
  localparam logic [7:0] SCR_RST_USER_CFG   = 8'h00;
  localparam logic [7:0] SCR_RST_CLK_SYSREF = 8'h80;
  localparam logic [7:0] SCR_RST_CLK_INMODE = 8'h00;
  localparam logic [7:0] SCR_RST_CLK_NOISE  = 8'h10;

  // config A: bit 7 reads zero, bit 4 always reads one
  localparam logic [7:0] SCR_CFGA_WMASK  = 8'h6F;
  localparam logic [7:0] SCR_CFGA_RO_ONE = 8'h10;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int unsigned SCR_BIT_ASCEND    = 5;
  localparam int unsigned SCR_BIT_ADDR_HOLD = 0;
  localparam int unsigned SCR_BIT_PROC_EN   = 6;
  localparam int unsigned SCR_BIT_RECV_EN   = 5;
  localparam int unsigned SCR_BIT_WSCALE    = 4;
  localparam int unsigned SCR_DSEL_MSB      = 3;
  localparam int unsigned SCR_BIT_POL_FLIP  = 0;
  localparam int unsigned SCR_BIT_SR_LVPECL = 1;
  localparam int unsigned SCR_BIT_DC_LVPECL = 2;
  localparam int unsigned SCR_BIT_VCLK_NS   = 0;
  localparam int unsigned SCR_BIT_VA_NS     = 2;

  // ----------------------------------------------------------------------
  // serial port sequencer states
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    SCR_IDLE = 2'b00,
    SCR_HDR  = 2'b01,
    SCR_DATA = 2'b10
  } scr_state_t;

endpackage : scr_pkg

// File: core/scr_sync.sv
// two-stage synchroniser for the asynchronous pins of the register bank
// assumes the pins are quasi-static relative to the 40 MHz clock
`timescale 1ns/1ps
module scr_sync
  import scr_pkg::*;
(
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  // pins in, synchronised levels out
  input  wire logic [SCR_SYNC_W-1:0] async_in,
  output logic      [SCR_SYNC_W-1:0] sync_out
);
  import scr_pkg::*;

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [SCR_SYNC_W-1:0] meta;   // first stage, read only by second
    logic [SCR_SYNC_W-1:0] stab;   // second stage, safe to use
  } scr_sync_st_t;

  scr_sync_st_t state_ff;          // registered state
  scr_sync_st_t nxt_state;         // next state

  // shift pins through both stages
  always_comb begin
    nxt_state      = state_ff;
    nxt_state.meta = async_in;
    nxt_state.stab = state_ff.meta;
  end

  // register; reset clears both stages, so select looks active for two
  // clocks after reset, which is harmless because no frame starts
  // without serial clock edges, and the serial clock idles low
  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign sync_out = state_ff.stab;

endmodule : scr_sync

// File: core/scr_sysref_regs.sv
// sysref clock control register bank behind the serial configuration port
// assumes a mode-0 serial host running its clock at most clk/8
//
// Summary of operation
// R01 - address hold keeps streaming address fixed
// R02 - hold clear, address steps by direction
// R03 - direction one increments, zero decrements
// R04 - processor enable gates sysref event handling
// R05 - host enables receiver before processor
// R06 - receiver enable bit powers receiver
// R07 - window scale selects finer delay steps
// R08 - host sets scale on multiple windows
// R09 - four-bit delay choice selects capture delay
// R10 - host picks delay from edge position
// R11 - edge position reads as 24-bit status
// R12 - polarity flip inverts alignment sysref
// R13 - host writes reserved fields with defaults
// R14 - reset values 0x80, 0x00, 0x10
// R15 - read-write fields read back last write
`timescale 1ns/1ps
module scr_sysref_regs
  import scr_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // serial configuration port pins
  input  wire logic        spi_sclk,
  input  wire logic        spi_cs_n,
  input  wire logic        spi_sdi,
  output logic             spi_sdo,
  // sysref pin and position detector status
  input  wire logic        sysref_pin,
  input  wire logic [23:0] sysref_edge_position,
  // control towards the clocking circuits
  output logic             sysref_processor_enable,
  output logic             sysref_receiver_enable,
  output logic             sysref_window_scale,
  output logic [3:0]       sysref_delay_choice,
  output logic             sysref_polarity_flip,
  output logic             sysref_lvpecl_enable,
  output logic             devclk_lvpecl_enable,
  output logic             va11_noise_suppress,
  output logic             vclk11_noise_suppress,
  // processed sysref event
  output logic             sysref_event
);
  import scr_pkg::*;

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    scr_state_t  st;        // sequencer state
    logic [3:0]  bitcnt;    // bit within header or byte
    logic [15:0] in_sr;     // shift-in register
    logic [7:0]  out_sr;    // shift-out register
    logic [14:0] addr;      // current streaming address
    logic        rd;        // frame is a read
    logic        sdo;       // serial data out
    logic        sclk_d;    // delayed clock for edge detect
    logic        srx_d;     // previous conditioned sysref
    logic        evt;       // sysref event pulse
    logic [7:0]  cfg_a;     // direction and reserved bits
    logic [7:0]  usr;       // user serial configuration
    logic [7:0]  ctl0;      // sysref clock control
    logic [7:0]  ctl1;      // clock input mode control
    logic [7:0]  ctl2;      // supply noise control
  } scr_regs_st_t;

  scr_regs_st_t state_ff;          // registered state
  scr_regs_st_t nxt_state;         // next state

  logic [SCR_SYNC_W-1:0] pins_s;   // synchronised pins
  logic s_sclk;                    // synced serial clock
  logic s_cs_n;                    // synced chip select
  logic s_sdi;                     // synced serial data in
  logic s_sysref;                  // synced sysref
  logic rise;                      // serial clock rising
  logic fall;                      // serial clock falling
  logic byte_done;                 // last bit of a data byte taken
  logic [7:0]  wbyte;              // completed data byte
  logic [14:0] hdr_addr;           // address in completed header
  logic srx;                       // conditioned sysref level

  // ----------------------------------------------------------------------
  // pin synchronisation
  // ----------------------------------------------------------------------
  scr_sync u_sync (
    .clk      (clk),
    .rst      (rst),
    .async_in ({sysref_pin, spi_sdi, spi_cs_n, spi_sclk}),
    .sync_out (pins_s)
  );

  assign s_sclk   = pins_s[0];
  assign s_cs_n   = pins_s[1];
  assign s_sdi    = pins_s[2];
  assign s_sysref = pins_s[3];

  assign rise      = s_sclk & ~state_ff.sclk_d;
  assign fall      = ~s_sclk & state_ff.sclk_d;
  assign byte_done = (state_ff.st == SCR_DATA) & ~s_cs_n & rise &
                     (state_ff.bitcnt == SCR_BYTE_LAST);
  assign wbyte     = {state_ff.in_sr[6:0], s_sdi};
  assign hdr_addr  = {state_ff.in_sr[13:0], s_sdi};

  // R12 polarity inversion
  // R06 receiver gating
  assign srx = state_ff.ctl0[SCR_BIT_RECV_EN] &
               (s_sysref ^ state_ff.ctl1[SCR_BIT_POL_FLIP]);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // read decode, used at header end and at every byte end
  function automatic logic [7:0] rd_byte(input logic [14:0] a);
    case (a)
      SCR_OFS_CONFIG_A:   rd_byte = (state_ff.cfg_a & SCR_CFGA_WMASK) |
                                    SCR_CFGA_RO_ONE;
      SCR_OFS_USER_CFG:   rd_byte = state_ff.usr;
      SCR_OFS_CLK_SYSREF: rd_byte = state_ff.ctl0;
      SCR_OFS_CLK_INMODE: rd_byte = state_ff.ctl1;
      SCR_OFS_CLK_NOISE:  rd_byte = state_ff.ctl2;
      // R11 edge position status
      SCR_OFS_EDGE_POS0:  rd_byte = sysref_edge_position[7:0];
      SCR_OFS_EDGE_POS1:  rd_byte = sysref_edge_position[15:8];
      SCR_OFS_EDGE_POS2:  rd_byte = sysref_edge_position[23:16];
      default:            rd_byte = 8'h00;  // unmapped reads zero
    endcase
  endfunction : rd_byte

  // next streaming address; wraps within the 15-bit space
  function automatic logic [14:0] step_addr(input logic [14:0] a);
    // R01 address hold
    if (state_ff.usr[SCR_BIT_ADDR_HOLD]) begin
      step_addr = a;
    // R02 R03 direction step
    end else if (state_ff.cfg_a[SCR_BIT_ASCEND]) begin
      step_addr = a + 15'h0001;
    end else begin
      step_addr = a - 15'h0001;
    end
  endfunction : step_addr

  // ----------------------------------------------------------------------
  // serial sequencer, register writes and sysref processing
  // ----------------------------------------------------------------------
  always_comb begin
    nxt_state        = state_ff;
    nxt_state.sclk_d = s_sclk;
    if (s_cs_n) begin
      // deselect aborts any partial byte; nothing is written
      nxt_state.st     = SCR_IDLE;
      nxt_state.bitcnt = 4'h0;
      nxt_state.sdo    = 1'b0;
    end else begin
      case (state_ff.st)
        SCR_IDLE: begin
          nxt_state.st     = SCR_HDR;
          nxt_state.bitcnt = 4'h0;
        end
        SCR_HDR: begin
          if (rise) begin
            nxt_state.in_sr  = {state_ff.in_sr[14:0], s_sdi};
            nxt_state.bitcnt = state_ff.bitcnt + 4'h1;
            if (state_ff.bitcnt == SCR_HDR_LAST) begin
              nxt_state.st     = SCR_DATA;
              nxt_state.bitcnt = 4'h0;
              nxt_state.rd     = state_ff.in_sr[SCR_BIT_RW - 1];
              nxt_state.addr   = hdr_addr;
              nxt_state.out_sr = rd_byte(hdr_addr);
            end
          end
        end
        SCR_DATA: begin
          if (rise) begin
            nxt_state.in_sr  = {state_ff.in_sr[14:0], s_sdi};
            nxt_state.bitcnt = state_ff.bitcnt + 4'h1;
            if (state_ff.bitcnt == SCR_BYTE_LAST) begin
              nxt_state.bitcnt = 4'h0;
              if (!state_ff.rd) begin
                // R15 stored as written
                // R09 R07 delay choice and scale
                case (state_ff.addr)
                  SCR_OFS_CONFIG_A:   nxt_state.cfg_a = wbyte;
                  SCR_OFS_USER_CFG:   nxt_state.usr   = wbyte;
                  SCR_OFS_CLK_SYSREF: nxt_state.ctl0  = wbyte;
                  SCR_OFS_CLK_INMODE: nxt_state.ctl1  = wbyte;
                  SCR_OFS_CLK_NOISE:  nxt_state.ctl2  = wbyte;
                  default: ;          // read-only or unmapped: ignored
                endcase
              end
              nxt_state.addr   = step_addr(state_ff.addr);
              nxt_state.out_sr = rd_byte(step_addr(state_ff.addr));
            end
          end else if (fall) begin
            // data changes on the falling edge, host samples on rising
            nxt_state.sdo    = state_ff.out_sr[7];
            nxt_state.out_sr = {state_ff.out_sr[6:0], 1'b0};
          end
        end
        default: nxt_state.st = SCR_IDLE;
      endcase
    end
    // R04 processor gates events
    nxt_state.srx_d = srx;
    nxt_state.evt   = state_ff.ctl0[SCR_BIT_PROC_EN] & srx & ~state_ff.srx_d;
  end

  // register
  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff       <= '0;
      state_ff.st    <= SCR_IDLE;
      // R14 reset values
      state_ff.cfg_a <= SCR_RST_CONFIG_A;
      state_ff.usr   <= SCR_RST_USER_CFG;
      state_ff.ctl0  <= SCR_RST_CLK_SYSREF;
      state_ff.ctl1  <= SCR_RST_CLK_INMODE;
      state_ff.ctl2  <= SCR_RST_CLK_NOISE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------------------------------------
  // outputs, all straight from flip-flops
  // ----------------------------------------------------------------------
  assign spi_sdo                 = state_ff.sdo;
  assign sysref_processor_enable = state_ff.ctl0[SCR_BIT_PROC_EN];
  assign sysref_receiver_enable  = state_ff.ctl0[SCR_BIT_RECV_EN];
  assign sysref_window_scale     = state_ff.ctl0[SCR_BIT_WSCALE];
  assign sysref_delay_choice     = state_ff.ctl0[SCR_DSEL_MSB:0];
  assign sysref_polarity_flip    = state_ff.ctl1[SCR_BIT_POL_FLIP];
  assign sysref_lvpecl_enable    = state_ff.ctl1[SCR_BIT_SR_LVPECL];
  assign devclk_lvpecl_enable    = state_ff.ctl1[SCR_BIT_DC_LVPECL];
  assign va11_noise_suppress     = state_ff.ctl2[SCR_BIT_VA_NS];
  assign vclk11_noise_suppress   = state_ff.ctl2[SCR_BIT_VCLK_NS];
  assign sysref_event            = state_ff.evt;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  addr_hold_a: assert property (@(posedge clk) disable iff (rst) // R01
    byte_done && state_ff.usr[SCR_BIT_ADDR_HOLD]
      |=> state_ff.addr == $past(state_ff.addr))
    else $error("streaming address moved while held");

  addr_up_a: assert property (@(posedge clk) disable iff (rst) // R02
    byte_done && !state_ff.usr[SCR_BIT_ADDR_HOLD] &&
    state_ff.cfg_a[SCR_BIT_ASCEND]
      |=> state_ff.addr == $past(state_ff.addr) + 15'h0001)
    else $error("streaming address did not increment");

  addr_down_a: assert property (@(posedge clk) disable iff (rst) // R03
    byte_done && !state_ff.usr[SCR_BIT_ADDR_HOLD] &&
    !state_ff.cfg_a[SCR_BIT_ASCEND]
      |=> state_ff.addr == $past(state_ff.addr) - 15'h0001)
    else $error("streaming address did not decrement");

  proc_gate_a: assert property (@(posedge clk) disable iff (rst) // R04
    sysref_event |-> $past(sysref_processor_enable) &&
                     $past(sysref_receiver_enable))
    else $error("sysref event while processing disabled");

  pol_flip_a: assert property (@(posedge clk) disable iff (rst) // R12
    sysref_event |-> ($past(s_sysref) ^ $past(sysref_polarity_flip)) &&
                     !($past(sysref_receiver_enable, 2) &&
                       ($past(s_sysref, 2) ^ $past(sysref_polarity_flip, 2))))
    else $error("sysref event not on conditioned rising edge");

  reset_val_a: assert property (@(posedge clk) // R14
    rst |=> state_ff.ctl0 == 8'h80 && state_ff.ctl1 == 8'h00 &&
            state_ff.ctl2 == 8'h10 && !sysref_processor_enable)
    else $error("wrong value after reset");

  wr_back_a: assert property (@(posedge clk) disable iff (rst) // R15
    byte_done && !state_ff.rd && state_ff.addr == SCR_OFS_CLK_INMODE
      |=> state_ff.ctl1 == $past(wbyte))
    else $error("clock input mode write not stored");

  delay_sel_a: assert property (@(posedge clk) disable iff (rst) // R09
    byte_done && !state_ff.rd && state_ff.addr == SCR_OFS_CLK_SYSREF
      |=> sysref_delay_choice == $past(wbyte[3:0]) &&
          sysref_window_scale == $past(wbyte[4]))
    else $error("delay choice or window scale not applied");

  pos_read_a: assert property (@(posedge clk) disable iff (rst) // R11
    state_ff.st == SCR_HDR && rise && !s_cs_n &&
    state_ff.bitcnt == SCR_HDR_LAST && hdr_addr == SCR_OFS_EDGE_POS0
      |=> state_ff.out_sr == $past(sysref_edge_position[7:0]))
    else $error("edge position byte not loaded for read");

endmodule : scr_sysref_regs

// File: tb/scr_host.sv
// serial configuration host model driving the sysref clock control bank
// assumes the device samples sdi on rising sclk and shifts sdo on falling
`timescale 1ns/1ps
module scr_host (
  // core clock used only to pace the pins
  input  wire logic clk,
  // serial port towards the device
  output logic      spi_sclk,
  output logic      spi_cs_n,
  output logic      spi_sdi,
  input  wire logic spi_sdo
);
  int half_clk = 6;  // clocks per sclk phase; 4 is the fastest legal

  // ----------------------------------------------------------------------
  // idle pins: clock parked low, device deselected
  // ----------------------------------------------------------------------
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_sdi  = 1'b1;
  end

  // wait clocks, then step just past the edge so pins never race it
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : tick

  // one bit: data set while low, both sides sample on the rise
  task automatic shift(input logic b, output logic s);
    spi_sdi = b;
    tick(half_clk);
    s        = spi_sdo;
    spi_sclk = 1'b1;
    tick(half_clk);
    spi_sclk = 1'b0;
  endtask : shift

  // release: the line is not pulled, so show the inverse of the last bit
  task automatic release_port();
    spi_sdi  = ~spi_sdi;
    spi_cs_n = 1'b1;
    tick(6);
  endtask : release_port

  // one frame: header, then one byte per entry of wq; rq collects sdo
  task automatic xfer(input  logic        rd,
                      input  logic [14:0] a,
                      input  logic [7:0]  wq[$],
                      output logic [7:0]  rq[$]);
    logic [15:0] h;
    logic [7:0]  b;
    logic        s;
    h        = {rd, a};
    rq       = {};
    spi_cs_n = 1'b0;
    tick(6);
    for (int i = 15; i >= 0; i--) shift(h[i], s);
    foreach (wq[k]) begin
      for (int i = 7; i >= 0; i--) begin
        shift(wq[k][i], s);
        b[i] = s;
      end
      rq.push_back(b);
    end
    // give the last byte time to commit before deselecting
    tick(6);
    release_port();
  endtask : xfer

  // write frame cut short after four data bits
  task automatic cut(input logic [14:0] a, input logic [7:0] d);
    logic [15:0] h;
    logic        s;
    h        = {1'b0, a};
    spi_cs_n = 1'b0;
    tick(6);
    for (int i = 15; i >= 0; i--) shift(h[i], s);
    for (int i = 7; i >= 4; i--) shift(d[i], s);
    release_port();
  endtask : cut
endmodule : scr_host

// File: tb/sysref_clock_control_regs_bench.sv
// self-checking bench for the sysref clock control register bank
// assumes scr_host as the serial master and a 40 MHz core clock
`timescale 1ns/1ps
module sysref_clock_control_regs_bench;
  import scr_pkg::*;

  // ----------------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------------
  logic        clk        = 1'b0;   // core clock
  logic        rst        = 1'b1;   // synchronous reset
  logic        sysref_pin = 1'b0;   // sysref level into the device
  logic [23:0] pos        = 24'h0;  // position detector status
  logic        sclk, cs_n, sdi, sdo;
  logic        proc_en, recv_en, wscale, flip, sr_pecl, dc_pecl;
  logic        va_ns, vclk_ns, ev;
  logic [3:0]  dsel;
  int          mismatches      = 0;
  int          samples_checked = 0;
  int          cycles          = 0;
  int          ev_cnt          = 0;

  always #12.5 clk = ~clk;

  scr_host host (.clk(clk), .spi_sclk(sclk), .spi_cs_n(cs_n),
                 .spi_sdi(sdi), .spi_sdo(sdo));

  scr_sysref_regs DUT (
    .clk(clk), .rst(rst), .spi_sclk(sclk), .spi_cs_n(cs_n),
    .spi_sdi(sdi), .spi_sdo(sdo), .sysref_pin(sysref_pin),
    .sysref_edge_position(pos), .sysref_processor_enable(proc_en),
    .sysref_receiver_enable(recv_en), .sysref_window_scale(wscale),
    .sysref_delay_choice(dsel), .sysref_polarity_flip(flip),
    .sysref_lvpecl_enable(sr_pecl), .devclk_lvpecl_enable(dc_pecl),
    .va11_noise_suppress(va_ns), .vclk11_noise_suppress(vclk_ns),
    .sysref_event(ev));

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  task automatic final_report();
    if (mismatches == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : final_report

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [14:0] a, input logic [7:0] q[$]);
    logic [7:0] r[$];
    host.xfer(1'b0, a, q, r);
  endtask : wr

  // streaming read; expected bytes double as filler on sdi
  task automatic rd(input logic [14:0] a, input logic [7:0] e[$]);
    logic [7:0] r[$];
    host.xfer(1'b1, a, e, r);
    foreach (e[i]) chk(r[i], e[i]);
  endtask : rd

  task automatic pin_set(input logic v);
    sysref_pin = v;
    repeat (8) @(posedge clk);
    #2;
  endtask : pin_set

  // count event pulses and cut a hang short
  always @(posedge clk) begin
    cycles++;
    if (ev === 1'b1) ev_cnt++;
    if (cycles == 60000) begin
      mismatches++;
      final_report();
    end
  end

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    #2 rst = 1'b0;
    repeat (6) @(posedge clk);
    #2;
    rd(SCR_OFS_CLK_SYSREF, {8'h80, 8'h00, 8'h10});
    rd(SCR_OFS_USER_CFG, {8'h00});
    chk({proc_en, recv_en, wscale, dsel, flip}, 8'h00);
    wr(SCR_OFS_CLK_SYSREF, {8'hA0});
    chk({proc_en, recv_en}, 2'b01);
    pin_set(1'b1);
    chk(ev_cnt, 0);
    wr(SCR_OFS_CLK_SYSREF, {8'hE0});
    chk({proc_en, recv_en}, 2'b11);
    pin_set(1'b0);
    pin_set(1'b1);
    chk(ev_cnt, 1);
    wr(SCR_OFS_CLK_INMODE, {8'h01});
    chk(flip, 1'b1);
    pin_set(1'b0);
    chk(ev_cnt, 2);
    pin_set(1'b1);
    chk(ev_cnt, 2);
    // ascending streaming write and read back
    wr(SCR_OFS_CLK_SYSREF, {8'h95, 8'h06, 8'h15});
    chk({proc_en, recv_en, wscale, dsel}, 7'h15);
    chk({dc_pecl, sr_pecl, flip, va_ns, vclk_ns}, 5'b11011);
    rd(SCR_OFS_CLK_SYSREF, {8'h95, 8'h06, 8'h15});
    // aborted byte leaves the register alone
    host.cut(SCR_OFS_CLK_SYSREF, 8'h00);
    rd(SCR_OFS_CLK_SYSREF, {8'h95});
    // descending read at the fastest clock
    wr(SCR_OFS_CONFIG_A, {8'h00});
    host.half_clk = 4;
    rd(SCR_OFS_CLK_NOISE, {8'h15, 8'h06, 8'h95});
    host.half_clk = 6;
    wr(SCR_OFS_CONFIG_A, {8'h20});
    rd(SCR_OFS_CONFIG_A, {8'h30});
    wr(SCR_OFS_USER_CFG, {8'h01});
    wr(SCR_OFS_CLK_INMODE, {8'h02, 8'h04});
    rd(SCR_OFS_CLK_INMODE, {8'h04, 8'h04});
    chk({dc_pecl, sr_pecl, flip}, 3'b100);
    wr(SCR_OFS_USER_CFG, {8'h00});
    rd(SCR_OFS_CLK_NOISE, {8'h15});
    pos = 24'hC3A55A;
    rd(SCR_OFS_EDGE_POS0, {8'h5A, 8'hA5, 8'hC3});
    wr(SCR_OFS_EDGE_POS2, {8'hFF});
    rd(SCR_OFS_EDGE_POS2, {8'hC3});
    rd(15'h007F, {8'h00});
    // host picks scale and delay from the position reading
    wr(SCR_OFS_CLK_SYSREF, {8'h93});
    chk({wscale, dsel}, 5'h13);
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #2 rst = 1'b0;
    repeat (6) @(posedge clk);
    #2;
    rd(SCR_OFS_CLK_SYSREF, {8'h80, 8'h00, 8'h10});
    chk({wscale, dsel, dc_pecl, va_ns, vclk_ns}, 8'h00);
    final_report();
  end
endmodule : sysref_clock_control_regs_bench
